// ---- core/gpio_port_pin_steering.sv ----
// Port pin logic: steering register, port D direction/analog, port E levels/direction.
// Assumes a simple register port and peripherals synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module gpio_port_pin_steering #(
    parameter bit REDUCED_PINS = 1'b0
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    // Select input routing
    input  wire logic        selPrimaryIn,
    input  wire logic        selAltIn,
    output logic             spiSelectIn,
    // Channel 2
    input  wire logic        ch2En,
    input  wire logic        ch2Out,
    input  wire logic        ch2Oe,
    output logic             ch2CaptureIn,
    // Port C bit 1 and port B bit 3 (channel-2 pins)
    input  wire logic        pc1In,
    input  wire logic        pb3In,
    input  wire logic        pc1Latch,
    input  wire logic        pc1DirInput,
    input  wire logic        pb3Latch,
    input  wire logic        pb3DirInput,
    output logic             pc1PadOut,
    output logic             pc1PadOe,
    output logic             pb3PadOut,
    output logic             pb3PadOe,
    // Port C bit 0: timer-1 oscillator and clock
    input  wire logic        pc0In,
    input  wire logic        pc0Latch,
    input  wire logic        pc0DirInput,
    input  wire logic        timer1OscEn,
    input  wire logic        timer1OscOut,
    input  wire logic        timer1ExtClkEn,
    output logic             timer1ClockInput,
    output logic             pc0PadOut,
    output logic             pc0PadOe,
    // Port C bit 7: serial receive / sync data
    input  wire logic        pc7In,
    input  wire logic        pc7Latch,
    input  wire logic        pc7DirInput,
    input  wire logic        serialEn,
    input  wire logic        serialSyncMaster,
    input  wire logic        serialSyncTx,
    input  wire logic        serialDataOut,
    output logic             serialReceiveData,
    output logic             pc7PadOut,
    output logic             pc7PadOe,
    // Port D pins
    input  wire logic [7:0]  portDIn,
    output logic      [7:0]  portDPadOut,
    output logic      [7:0]  portDPadOe,
    output logic      [7:0]  portDDigitalIn,
    output logic      [7:0]  portDAnalogEn,
    input  wire logic [3:0]  capSenseEn,
    output logic      [3:0]  capSenseInput,
    // Port E pins
    input  wire logic [3:0]  portEIn,
    output logic      [2:0]  portEPadOut,
    output logic      [2:0]  portEPadOe
);
    logic [7:0] steer_q, steer_d;
    logic [7:0] dDir_q, dDir_d;
    logic [7:0] dAna_q, dAna_d;
    logic [7:0] dLat_q, dLat_d;
    logic [2:0] eDir_q, eDir_d;
    logic [2:0] eLat_q, eLat_d;
    logic [3:0] eLevel_q;
    logic [7:0] rd_q, rd_d;
    logic       ch2OwnsPortC;
    logic       ch2OwnsPortB;
    logic [7:0] dDirView;
    logic [7:0] dAnaView;
    logic [3:0] eLevelView;
    logic [3:0] eDirView;

    always_comb begin
        steer_d = steer_q;
        dDir_d  = dDir_q;
        dAna_d  = dAna_q;
        dLat_d  = dLat_q;
        eDir_d  = eDir_q;
        eLat_d  = eLat_q;
        if (regWrite) begin
            unique case (regAddr)
                gpio_steer_pkg::ADDR_PIN_STEERING:
                    steer_d = regWrData & gpio_steer_pkg::STEER_MASK;
                gpio_steer_pkg::ADDR_PORT_D_DIR: dDir_d = regWrData;
                gpio_steer_pkg::ADDR_PORT_D_ANA: dAna_d = regWrData;
                gpio_steer_pkg::ADDR_PORT_D_OUT: dLat_d = regWrData;
                gpio_steer_pkg::ADDR_PORT_E_DIR: eDir_d = regWrData[2:0];
                gpio_steer_pkg::ADDR_PORT_E_LEVEL,
                gpio_steer_pkg::ADDR_PORT_E_OUT: eLat_d = regWrData[2:0];
                default: ;
            endcase
        end
    end

    // Absent port D and port E bits read as zero on the reduced build; port E bit 3 reads as in the full build
    always_comb begin
        dDirView   = REDUCED_PINS ? 8'h00 : dDir_q;
        dAnaView   = REDUCED_PINS ? 8'h00 : dAna_q;
        eLevelView = REDUCED_PINS ? {eLevel_q[3], 3'h0} : eLevel_q;
        eDirView   = REDUCED_PINS ? 4'h8 : {1'b1, eDir_q};
    end

    always_comb begin
        rd_d = gpio_steer_pkg::UNMAPPED_READ;
        if (regRead) begin
            unique case (regAddr)
                gpio_steer_pkg::ADDR_PIN_STEERING: rd_d = steer_q & gpio_steer_pkg::STEER_MASK;
                gpio_steer_pkg::ADDR_PORT_D_DIR:   rd_d = dDirView;
                gpio_steer_pkg::ADDR_PORT_D_ANA:   rd_d = dAnaView;
                gpio_steer_pkg::ADDR_PORT_D_OUT:   rd_d = REDUCED_PINS ? 8'h00 : dLat_q;
                gpio_steer_pkg::ADDR_PORT_E_LEVEL: rd_d = {4'h0, eLevelView};
                gpio_steer_pkg::ADDR_PORT_E_DIR:   rd_d = {4'h0, eDirView};
                gpio_steer_pkg::ADDR_PORT_E_OUT:   rd_d = REDUCED_PINS ? 8'h00 : {5'h00, eLat_q};
                default:                           rd_d = gpio_steer_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            steer_q  <= gpio_steer_pkg::STEER_RESET;
            dDir_q   <= gpio_steer_pkg::PORT_D_DIR_RST;
            dAna_q   <= gpio_steer_pkg::PORT_D_ANA_RST;
            dLat_q   <= gpio_steer_pkg::LATCH_RESET;
            eDir_q   <= gpio_steer_pkg::PORT_E_DIR_RST;
            eLat_q   <= 3'h0;
            eLevel_q <= 4'h0;
            rd_q     <= 8'h00;
        end else begin
            steer_q  <= steer_d;
            dDir_q   <= dDir_d;
            dAna_q   <= dAna_d;
            dLat_q   <= dLat_d;
            eDir_q   <= eDir_d;
            eLat_q   <= eLat_d;
            eLevel_q <= portEIn;
            rd_q     <= rd_d;
        end
    end

    assign regRdData = rd_q;

    pin_steer_route uRoute (
        .selectInputSteer (steer_q[gpio_steer_pkg::BIT_SELECT_STEER]),
        .channel2Steer    (steer_q[gpio_steer_pkg::BIT_CH2_STEER]),
        .selPrimaryIn     (selPrimaryIn),
        .selAltIn         (selAltIn),
        .ch2PortCIn       (pc1In),
        .ch2PortBIn       (pb3In),
        .ch2En            (ch2En),
        .spiSelectIn      (spiSelectIn),
        .ch2CaptureIn     (ch2CaptureIn),
        .ch2OwnsPortC     (ch2OwnsPortC),
        .ch2OwnsPortB     (ch2OwnsPortB)
    );

    pin_mux_cell uPc1 (
        .latchValue (pc1Latch),
        .dirInput   (pc1DirInput),
        .periphOwn  (ch2OwnsPortC),
        .periphOut  (ch2Out),
        .periphOe   (ch2Oe),
        .padOut     (pc1PadOut),
        .padOe      (pc1PadOe)
    );

    pin_mux_cell uPb3 (
        .latchValue (pb3Latch),
        .dirInput   (pb3DirInput),
        .periphOwn  (ch2OwnsPortB),
        .periphOut  (ch2Out),
        .periphOe   (ch2Oe),
        .padOut     (pb3PadOut),
        .padOe      (pb3PadOe)
    );

    // Oscillator drive wins; external clock mode keeps the driver off
    pin_mux_cell uPc0 (
        .latchValue (pc0Latch),
        .dirInput   (pc0DirInput),
        .periphOwn  (timer1OscEn | timer1ExtClkEn),
        .periphOut  (timer1OscOut),
        .periphOe   (timer1OscEn),
        .padOut     (pc0PadOut),
        .padOe      (pc0PadOe)
    );
    assign timer1ClockInput = timer1ExtClkEn & pc0In;

    // Sync transmit drives the data line; otherwise it is a receive input
    pin_mux_cell uPc7 (
        .latchValue (pc7Latch),
        .dirInput   (pc7DirInput),
        .periphOwn  (serialEn),
        .periphOut  (serialDataOut),
        .periphOe   (serialSyncTx),
        .padOut     (pc7PadOut),
        .padOe      (pc7PadOe)
    );
    assign serialReceiveData = serialEn & pc7In & ~(serialSyncMaster & serialSyncTx);

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : gPortD
            logic own;
            if (i < 4) begin : gCap
                assign own = capSenseEn[i];
                assign capSenseInput[i] = capSenseEn[i] & dAnaView[i];
            end else begin : gNoCap
                assign own = 1'b0;
            end
            // Cap-sense ownership drops the driver on bits 0-3; analog select does not, so software must also set direction
            pin_mux_cell uCell (
                .latchValue (REDUCED_PINS ? 1'b0 : dLat_q[i]),
                .dirInput   (dDirView[i] | REDUCED_PINS),
                .periphOwn  (own),
                .periphOut  (1'b0),
                .periphOe   (1'b0),
                .padOut     (portDPadOut[i]),
                .padOe      (portDPadOe[i])
            );
            assign portDAnalogEn[i]  = dAnaView[i];
            assign portDDigitalIn[i] = ~dAnaView[i] & portDIn[i];
        end
        for (i = 0; i < 3; i++) begin : gPortE
            assign portEPadOut[i] = REDUCED_PINS ? 1'b0 : eLat_q[i];
            assign portEPadOe[i]  = REDUCED_PINS ? 1'b0 : ~eDir_q[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ---- core/gpio_steer_pkg.sv ----
// Package for the port pin steering block: register map, field positions, reset values.
// Assumes an 8-bit register port with one-cycle read latency.
package gpio_steer_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_PIN_STEERING = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PORT_D_DIR   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PORT_D_ANA   = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PORT_E_LEVEL = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_PORT_E_DIR   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PORT_E_OUT   = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_PORT_D_OUT   = 4'h6;
    localparam int BIT_CH2_STEER    = 0;
    localparam int BIT_SELECT_STEER = 1;
    localparam int BIT_E3           = 3;
    localparam logic [7:0] STEER_MASK     = 8'h03;
    localparam logic [7:0] STEER_RESET    = 8'h00;
    localparam logic [7:0] PORT_D_DIR_RST = 8'hFF;
    localparam logic [7:0] PORT_D_ANA_RST = 8'hFF;
    localparam logic [2:0] PORT_E_DIR_RST = 3'h7;
    localparam logic [7:0] LATCH_RESET    = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;
endpackage

// ---- core/pin_mux_cell.sv ----
// One pin's output selection between port latch and a peripheral.
// Assumes peripheral enables come from synchronous on-chip logic.
`timescale 1ns/100ps
`default_nettype none
module pin_mux_cell (
    // Port side
    input  wire logic latchValue,
    input  wire logic dirInput,
    // Peripheral side
    input  wire logic periphOwn,
    input  wire logic periphOut,
    input  wire logic periphOe,
    // Pad side
    output logic      padOut,
    output logic      padOe
);
    always_comb begin
        if (periphOwn) begin
            padOut = periphOut;
            padOe  = periphOe;
        end else begin
            padOut = latchValue;
            padOe  = ~dirInput;
        end
    end
endmodule
`default_nettype wire

// ---- core/pin_steer_route.sv ----
// Routes the select input and channel-2 signals between their two candidate pins.
// Assumes pin inputs are synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module pin_steer_route (
    // Steering controls
    input  wire logic selectInputSteer,
    input  wire logic channel2Steer,
    // Pin inputs
    input  wire logic selPrimaryIn,
    input  wire logic selAltIn,
    input  wire logic ch2PortCIn,
    input  wire logic ch2PortBIn,
    // Peripheral side
    input  wire logic ch2En,
    output logic      spiSelectIn,
    output logic      ch2CaptureIn,
    // Ownership of the channel-2 pins
    output logic      ch2OwnsPortC,
    output logic      ch2OwnsPortB
);
    always_comb begin
        spiSelectIn  = selectInputSteer ? selAltIn : selPrimaryIn;
        ch2CaptureIn = channel2Steer ? ch2PortBIn : ch2PortCIn;
        ch2OwnsPortC = ch2En & ~channel2Steer;
        ch2OwnsPortB = ch2En & channel2Steer;
    end
endmodule
`default_nettype wire

// ---- test/gpio_port_pin_steering_properties.sv ----
// Concurrent checks on the pin steering block, seen from its top-level ports.
// Assumes one mclk domain; bound to every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
module gpio_port_pin_steering_properties #(
    parameter bit REDUCED_PINS = 1'b0
) (
    // Clock, reset and register port
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // Steered functions
    input wire logic       selPrimaryIn, selAltIn, spiSelectIn,
    input wire logic       ch2En, ch2Out, pc1In, pb3In, ch2CaptureIn, pc1PadOut,
    // Port D
    input wire logic [7:0] portDIn, portDDigitalIn, portDAnalogEn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Shadow of the steering bits, rebuilt from bus writes
    logic [1:0] steerQ;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b) steerQ <= 2'b00;
        else if (regWrite && regAddr == gpio_steer_pkg::ADDR_PIN_STEERING) steerQ <= regWrData[1:0];

    chk_steer_readback: assert property (
        regRead && regAddr == gpio_steer_pkg::ADDR_PIN_STEERING
        |=> regRdData == {6'h00, $past(steerQ)}) else $error("steering readback wrong");
    chk_select_route: assert property (
        spiSelectIn == (steerQ[1] ? selAltIn : selPrimaryIn)) else $error("select misrouted");
    chk_ch2_capture: assert property (
        ch2CaptureIn == (steerQ[0] ? pb3In : pc1In)) else $error("capture misrouted");
    chk_ch2_pin_owned: assert property (
        ch2En && !steerQ[0] |-> pc1PadOut == ch2Out) else $error("pin not given to channel 2");
    chk_digital_buffer: assert property (
        portDDigitalIn == (~portDAnalogEn & portDIn)) else $error("digital buffer not gated");
    chk_analog_reset: assert property (
        $rose(rst_b) |-> portDAnalogEn == (REDUCED_PINS ? 8'h00 : 8'hFF))
        else $error("analog select reset wrong");
    chk_analog_write: assert property (
        regWrite && regAddr == gpio_steer_pkg::ADDR_PORT_D_ANA
        |=> portDAnalogEn == (REDUCED_PINS ? 8'h00 : $past(regWrData)))
        else $error("analog select not written");
    chk_edir_bit_three: assert property (
        regRead && regAddr == gpio_steer_pkg::ADDR_PORT_E_DIR
        |=> regRdData[7:3] == 5'h01) else $error("port E direction bit 3 not one");

    cover property (regWrite && regAddr == gpio_steer_pkg::ADDR_PIN_STEERING && regWrData[0]);
    cover property (ch2En && !steerQ[0]);
    cover property (regRead && regAddr == gpio_steer_pkg::ADDR_PORT_E_LEVEL);
endmodule
// The checker follows the build option of whichever instance it lands in
bind gpio_port_pin_steering gpio_port_pin_steering_properties #(
    .REDUCED_PINS (REDUCED_PINS)
) chk_i (.*);
`default_nettype wire

// ---- test/pin_side_model.sv ----
// Pin-side model: each pad level is the block's drive or an outside source.
// Assumes undriven pins see one bit of an LFSR that shifts every clock.
`timescale 1ns/100ps
`default_nettype none
module pin_side_model (
    // Clock and pad drive from the block
    input  wire logic       mclk,
    input  wire logic       pc1PadOut, pc1PadOe, pb3PadOut, pb3PadOe,
    input  wire logic       pc0PadOut, pc0PadOe, pc7PadOut, pc7PadOe,
    input  wire logic [7:0] portDPadOut, portDPadOe,
    input  wire logic [2:0] portEPadOut, portEPadOe,
    // Levels seen on the pins
    output logic            selPrimaryIn, selAltIn, pc1In, pb3In, pc0In, pc7In,
    output logic      [7:0] portDIn,
    output logic      [3:0] portEIn
);
    // A free LFSR, so a released pin never keeps its last driven value
    logic [7:0] ext = 8'h5A;
    always @(posedge mclk) ext <= {ext[6:0], ext[7] ^ ext[5] ^ ext[4] ^ ext[3]};
    assign selPrimaryIn = ext[0];
    assign selAltIn = ext[1];
    assign pc1In = pc1PadOe ? pc1PadOut : ext[2];
    assign pb3In = pb3PadOe ? pb3PadOut : ext[3];
    assign pc0In = pc0PadOe ? pc0PadOut : ext[4];
    assign pc7In = pc7PadOe ? pc7PadOut : ext[5];
    assign portDIn = (portDPadOe & portDPadOut) | (~portDPadOe & ext);
    assign portEIn = {ext[6], (portEPadOe & portEPadOut) | (~portEPadOe & ext[2:0])};
endmodule
`default_nettype wire

// ---- test/gpio_port_pin_steering_tb.sv ----
// Self-checking bench: register map, reset values and pin routing under random stimulus.
// Assumes the pin model closes the pad loop and the checker is bound to the block.
`timescale 1ns/100ps
`default_nettype none
module gpio_port_pin_steering_tb;
    logic        mclk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [3:0]  regAddr = 4'h0, eS, capSenseEn, capSenseInput, portEIn;
    logic [7:0]  regWrData = 8'h00, regRdData, rdv, st, dd, an;
    logic [7:0]  portDIn, portDPadOut, portDPadOe, portDDigitalIn, portDAnalogEn;
    logic [2:0]  portEPadOut, portEPadOe, eOeR;
    logic [7:0]  rdR, rdvR, dOeR, anR;
    logic [21:0] rnd = 22'h0;
    logic        selPrimaryIn, selAltIn, spiSelectIn, ch2En, ch2Out, ch2Oe, ch2CaptureIn;
    logic        pc1In, pb3In, pc1Latch, pc1DirInput, pb3Latch, pb3DirInput;
    logic        pc1PadOut, pc1PadOe, pb3PadOut, pb3PadOe, pc0In, pc0Latch, pc0DirInput;
    logic        timer1OscEn, timer1OscOut, timer1ExtClkEn, timer1ClockInput, pc0PadOut;
    logic        pc0PadOe, pc7In, pc7Latch, pc7DirInput, serialEn, serialSyncMaster;
    logic        serialSyncTx, serialDataOut, serialReceiveData, pc7PadOut, pc7PadOe;
    int          seed = 3043, bad_count = 0, tests_run = 0;
    logic [3:0]  ra [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF};
    logic [7:0]  rv [5] = '{8'h00, 8'hFF, 8'hFF, 8'h0F, 8'h00};

    assign {ch2En, ch2Out, ch2Oe, pc1Latch, pc1DirInput, pb3Latch, pb3DirInput, pc0Latch,
            pc0DirInput, timer1OscEn, timer1OscOut, timer1ExtClkEn, pc7Latch, pc7DirInput,
            serialEn, serialSyncMaster, serialSyncTx, serialDataOut, capSenseEn} = rnd;

    gpio_port_pin_steering dut (.*);
    pin_side_model pins (.*);

    // Reduced-pin build shares every input; its port D reads and port drives must show zero, its port E reads keep only bit 3
    gpio_port_pin_steering #(
        .REDUCED_PINS (1'b1)
    ) dutSmall (
        .*,
        .regRdData         (rdR),
        .spiSelectIn       (),
        .ch2CaptureIn      (),
        .pc1PadOut         (),
        .pc1PadOe          (),
        .pb3PadOut         (),
        .pb3PadOe          (),
        .timer1ClockInput  (),
        .pc0PadOut         (),
        .pc0PadOe          (),
        .serialReceiveData (),
        .pc7PadOut         (),
        .pc7PadOe          (),
        .portDPadOut       (),
        .portDPadOe        (dOeR),
        .portDDigitalIn    (),
        .portDAnalogEn     (anR),
        .capSenseInput     (),
        .portEPadOut       (),
        .portEPadOe        (eOeR)
    );

    always #12.5 mclk = ~mclk;

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    // Port E levels are sampled one edge ahead of the read, so note them there
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        eS = portEIn;
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        d = regRdData;
        rdvR = rdR;
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    function automatic logic [7:0] rdExp(input logic [3:0] a, input logic [7:0] v);
        case (a)
            4'h0: rdExp = v & gpio_steer_pkg::STEER_MASK;
            4'h4: rdExp = {4'h0, 1'b1, v[2:0]};
            default: rdExp = v;
        endcase
    endfunction

    task report_and_stop;
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(5000 * 25);
        bad_count++;
        report_and_stop;
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], rdv);
            chk(rdv, rv[i]);
        end
        for (int i = 0; i < 40; i++) begin
            st = $random(seed);
            dd = $random(seed);
            an = $random(seed);
            if (i < 2) st = i ? 8'h00 : 8'hFF;
            wr(4'h0, st);
            rd(4'h0, rdv);
            chk(rdv, rdExp(4'h0, st));
            wr(4'h1, dd | an);
            wr(4'h2, an);
            rd(4'h1, rdv);
            chk(rdv, dd | an);
            chk(rdvR, 8'h00);
            rd(4'h2, rdv);
            chk(rdv, an);
            chk(rdvR, 8'h00);
            wr(4'h4, dd);
            rd(4'h4, rdv);
            chk(rdv, rdExp(4'h4, dd));
            chk(rdvR, 8'h08);
            wr(4'h5, st);
            wr(4'h6, ~an);
            rd(4'h3, rdv);
            chk(rdv, {4'h0, eS});
            chk(rdvR, {4'h0, eS[3], 3'h0});
            @(posedge mclk) rnd <= 22'($random(seed));
            #1;
            chk(portDPadOe, ~(dd | an) & {4'hF, ~capSenseEn});
            chk({2'b0, portEPadOe, portEPadOut}, {2'b0, ~dd[2:0], st[2:0]});
            chk({capSenseInput, 4'h0}, {capSenseEn & an[3:0], 4'h0});
            chk({2'b0, spiSelectIn, ch2CaptureIn, pb3PadOe, timer1ClockInput, serialReceiveData,
                 pc1PadOut}, {2'b0, st[1] ? selAltIn : selPrimaryIn, st[0] ? pb3In : pc1In,
                 st[0] & ch2En ? ch2Oe : ~pb3DirInput, timer1ExtClkEn & pc0In,
                 serialEn & pc7In & ~(serialSyncMaster & serialSyncTx),
                 ~st[0] & ch2En ? ch2Out : pc1Latch});
            chk({1'b0, pc1PadOe, pb3PadOut, pc0PadOut, pc0PadOe, pc7PadOut, pc7PadOe, 1'b0},
                {1'b0, ~st[0] & ch2En ? ch2Oe : ~pc1DirInput,
                 st[0] & ch2En ? ch2Out : pb3Latch,
                 timer1OscEn | timer1ExtClkEn ? timer1OscOut : pc0Latch,
                 timer1OscEn | timer1ExtClkEn ? timer1OscEn : ~pc0DirInput,
                 serialEn ? serialDataOut : pc7Latch,
                 serialEn ? serialSyncTx : ~pc7DirInput, 1'b0});
            chk(portDPadOut, ~an & {4'hF, ~capSenseEn});
            chk(dOeR | anR | {5'h00, eOeR}, 8'h00);
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
